/* tmr_defines.svh */
/*
 Constants for the timer, PWM, buzzer and IR carrier unit.
 Assumes a 250 MHz core clock; included by the design.
*/
`ifndef TMR_DEFINES_SVH
`define TMR_DEFINES_SVH
`define CLK_HZ          250000000
`define IR_38K_HZ       38000
`define IR_57K_HZ       57000
`define IR_38K_HALF     ((`CLK_HZ / `IR_38K_HZ) / 2)
`define IR_57K_HALF     ((`CLK_HZ / `IR_57K_HZ) / 2)
`define UP_RESET        8'h00
`define DOWN_RESET      8'hff
`define DOWN_UNDER      8'h00
`define DOWN_FULL       8'hff
`define BZ_SEL_BIT      3
`endif

/* tmr_pkg.sv */
/*
 Types for the timer unit.
 Assumes tmr_defines.svh sits in the include path.
*/
`default_nettype none
package tmr_pkg;
   // Up-counter controls
   typedef struct packed {
      logic       enable;
      logic       sourceSelect;
      logic       lowClockSelect;
      logic       edgeSelect;
      logic       prescalerAssign;
      logic [2:0] ratio;
   } up_ctrl_t;
   // Down-counter controls
   typedef struct packed {
      logic       enable;
      logic       sourceSelect;
      logic       edgeSelect;
      logic       prescalerEnableN;
      logic [2:0] ratio;
      logic       oneShot;
      logic       reloadSelect;
   } down_ctrl_t;
   // Waveform controls
   typedef struct packed {
      logic       pwmOutputEnable;
      logic       pwmActiveLow;
      logic [7:0] pwmDuty;
      logic       buzzerEnable;
      logic [3:0] buzzerFreqSelect;
      logic       irEnable;
      logic       irFreqSelect;
      logic       irPolaritySelect;
   } wave_ctrl_t;
   typedef enum logic [1:0] {SRC_INST, SRC_EXT, SRC_LOW} up_src_t;
endpackage : tmr_pkg
`default_nettype wire

/* timers_pwm_buzzer_ir.sv */
/*
 Timer unit: 8-bit up-counter with shared prescaler, 8-bit down-counter with
 own prescaler, PWM, buzzer and IR carrier. Assumes firmware writes arrive as
 one-cycle strobes; config options are static after reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tmr_defines.svh"
module timers_pwm_buzzer_ir
(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rst_b,
   // Control bits
   input  wire tmr_pkg::up_ctrl_t   upCtrl,
   input  wire tmr_pkg::down_ctrl_t downCtrl,
   input  wire tmr_pkg::wave_ctrl_t waveCtrl,
   input  wire logic              globalIrqEnable,
   input  wire logic              upIrqEnable,
   input  wire logic              downIrqEnable,
   // Configuration options
   input  wire logic              cfgAsyncClock,
   input  wire logic              cfgPinIsPwm,
   // Firmware writes
   input  wire logic              upWrite,
   input  wire logic              downWrite,
   input  wire logic [7:0]        writeData,
   input  wire logic              prescalerAssignWrite,
   input  wire logic              upFlagClear,
   input  wire logic              downFlagClear,
   // External sources
   input  wire logic              extCountClockPin,
   input  wire logic              lowSpeedOsc,
   input  wire logic              irPortData,
   // Status
   output logic [7:0]             upCount,
   output logic [7:0]             downCount,
   output logic [7:0]             downReload,
   output logic [7:0]             prescalerBCount,
   output logic                   upOverflowFlag,
   output logic                   downUnderflowFlag,
   output logic                   irqRequest,
   // Pins
   output logic                   sharedWaveOut,
   output logic                   sharedWaveOe,
   output logic                   irOut,
   output logic                   irOe
);
   import tmr_pkg::*;

   localparam int IR38 = `IR_38K_HALF;
   localparam int IR57 = `IR_57K_HALF;
   if (IR38 < 1 || IR57 < 1 || IR38 > 65535 || IR57 > 65535) $error("IR divider does not fit its counter");

   // Prescaler tap for ratio 1:2^(r+1); edge pick on a conditioned level, fall for high-to-low
   function automatic logic tap(input logic [7:0] cnt, input logic [2:0] r);
      tap = &(cnt | ~8'((9'h2 << r) - 9'h1));
   endfunction : tap
   function automatic logic edgeHit(input logic prev, input logic now, input logic fall);
      edgeHit = fall ? (prev & ~now) : (~prev & now);
   endfunction : edgeHit

   logic [2:0] extSync, lowSync;
   logic       extPrev, lowPrev, extAsyncPrev, lowAsyncPrev;

   // Three stages; a change counts once stages two and three agree
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         extSync      <= 3'h0;
         lowSync      <= 3'h0;
         extPrev      <= 1'b0;
         lowPrev      <= 1'b0;
         extAsyncPrev <= 1'b0;
         lowAsyncPrev <= 1'b0;
      end
      else
      begin
         extSync      <= {extSync[1:0], extCountClockPin};
         lowSync      <= {lowSync[1:0], lowSpeedOsc};
         if (extSync[1] == extSync[2]) extPrev <= extSync[2];
         if (lowSync[1] == lowSync[2]) lowPrev <= lowSync[2];
         extAsyncPrev <= extSync[1]; // Async path is one stage earlier, still bound by the clock rate
         lowAsyncPrev <= lowSync[1];
      end
   end

   logic extNow, lowNow, extOld, lowOld, extTick, lowTick, upSrcTick, downSrcTick, upTick;
   up_src_t upSrc;
   always_comb
   begin
      extNow = cfgAsyncClock ? extSync[1] : extSync[2];
      lowNow = cfgAsyncClock ? lowSync[1] : lowSync[2];
      extOld = cfgAsyncClock ? extAsyncPrev : extPrev;
      lowOld = cfgAsyncClock ? lowAsyncPrev : lowPrev;
      if (!cfgAsyncClock && extSync[1] != extSync[2]) extNow = extPrev;
      if (!cfgAsyncClock && lowSync[1] != lowSync[2]) lowNow = lowPrev;
      // Edge select: 1 counts falling, 0 rising
      extTick = edgeHit(extOld, extNow, upCtrl.edgeSelect);
      lowTick = edgeHit(lowOld, lowNow, upCtrl.edgeSelect);
      if (!upCtrl.sourceSelect) upSrc = SRC_INST;
      else if (!upCtrl.lowClockSelect) upSrc = SRC_EXT;
      else upSrc = SRC_LOW;
      case (upSrc)
         SRC_INST: upSrcTick = 1'b1;
         SRC_EXT:  upSrcTick = extTick;
         SRC_LOW:  upSrcTick = lowTick;
         default:  upSrcTick = 1'b0;
      endcase
      downSrcTick = downCtrl.sourceSelect ? edgeHit(extOld, extNow, downCtrl.edgeSelect) : 1'b1;
   end

   // Prescaler A, cleared by any prescaler assignment write strobe
   logic [7:0] prescalerA;
   always_ff @(posedge clk)
   begin
      if (!rst_b || prescalerAssignWrite)
         prescalerA <= 8'h00;
      else if (upSrcTick && !upCtrl.prescalerAssign)
         prescalerA <= prescalerA + 8'h01;
   end
   assign upTick = upSrcTick && (upCtrl.prescalerAssign || tap(prescalerA, upCtrl.ratio));

   // Up counter and overflow flag; set beats clear
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         upCount        <= `UP_RESET;
         upOverflowFlag <= 1'b0;
      end
      else
      begin
         if (upWrite) upCount <= writeData;
         else if (upCtrl.enable && upTick) upCount <= upCount + 8'h01;
         if (upCtrl.enable && upTick && !upWrite && upCount == 8'hff) upOverflowFlag <= 1'b1;
         else if (upFlagClear) upOverflowFlag <= 1'b0;
      end
   end

   // Prescaler B; bypassed when its active-low enable is 1
   logic downTick, presBOut, downRun, underflow;
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         prescalerBCount <= 8'h00;
      else if (downSrcTick && downCtrl.enable)
         prescalerBCount <= prescalerBCount + 8'h01;
   end
   assign presBOut = downSrcTick && downCtrl.enable && tap(prescalerBCount, downCtrl.ratio);
   assign downTick = downCtrl.prescalerEnableN ? (downSrcTick && downCtrl.enable) : presBOut;
   assign underflow = downRun && downTick && downCount == `DOWN_UNDER;

   // Down counter with one-shot and continuous restart
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         downCount         <= `DOWN_RESET;
         downReload        <= `DOWN_RESET;
         downRun           <= 1'b0;
         downUnderflowFlag <= 1'b0;
      end
      else
      begin
         if (downWrite)
         begin
            downCount  <= writeData;
            downReload <= writeData;
            downRun    <= 1'b1;
         end
         else if (underflow)
         begin
            if (downCtrl.oneShot) downRun <= 1'b0;
            else downCount <= downCtrl.reloadSelect ? downReload : `DOWN_FULL;
         end
         else if (downRun && downTick)
            downCount <= downCount - 8'h01;
         if (!downCtrl.enable || !downCtrl.oneShot) downRun <= downWrite || downCtrl.enable || downRun;
         if (underflow) downUnderflowFlag <= 1'b1;
         else if (downFlagClear) downUnderflowFlag <= 1'b0;
      end
   end

   // Interrupt request under the global gate
   always_ff @(posedge clk)
   begin
      if (!rst_b) irqRequest <= 1'b0;
      else irqRequest <= globalIrqEnable &&
         ((upOverflowFlag && upIrqEnable) || (downUnderflowFlag && downIrqEnable));
   end

   // PWM active while count is below duty; duty 0 never active
   logic pwmActive;
   assign pwmActive = downCount < waveCtrl.pwmDuty;

   // Buzzer toggles on divided prescaler or timer events
   logic [7:0] bzDiv;
   logic       bzLevel, bzSrc;
   assign bzSrc = waveCtrl.buzzerFreqSelect[`BZ_SEL_BIT] ? underflow : presBOut;
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         bzDiv   <= 8'h00;
         bzLevel <= 1'b0;
      end
      else if (bzSrc)
      begin
         bzDiv <= bzDiv + 8'h01;
         if (tap(bzDiv, waveCtrl.buzzerFreqSelect[2:0])) bzLevel <= ~bzLevel;
      end
   end

   // Shared pin; config choice is a static input, not a register
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         sharedWaveOut <= 1'b0;
         sharedWaveOe  <= 1'b0;
      end
      else if (cfgPinIsPwm)
      begin
         sharedWaveOe  <= waveCtrl.pwmOutputEnable;
         sharedWaveOut <= pwmActive ^ waveCtrl.pwmActiveLow;
      end
      else
      begin
         sharedWaveOe  <= waveCtrl.buzzerEnable;
         sharedWaveOut <= bzLevel;
      end
   end

   // IR carrier from the core clock; half-period counter
   logic [15:0] irDiv;
   logic        irCarrier;
   always_ff @(posedge clk)
   begin
      if (!rst_b || !waveCtrl.irEnable)
      begin
         irDiv     <= 16'h0000;
         irCarrier <= 1'b0;
      end
      else if (irDiv >= 16'((waveCtrl.irFreqSelect ? IR57 : IR38) - 1))
      begin
         irDiv     <= 16'h0000;
         irCarrier <= ~irCarrier;
      end
      else
         irDiv <= irDiv + 16'h0001;
   end

   // Carrier present when port data differs from polarity choice
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         irOut <= 1'b0;
         irOe  <= 1'b0;
      end
      else
      begin
         irOe  <= waveCtrl.irEnable;
         irOut <= (irPortData ^ waveCtrl.irPolaritySelect) ? irCarrier : 1'b0;
      end
   end

   // Assertions
   property p_flag_sticky;
      @(posedge clk) disable iff (!rst_b) upOverflowFlag && !upFlagClear |=> upOverflowFlag;
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("overflow flag dropped");
   property p_irq_gate;
      @(posedge clk) disable iff (!rst_b) !globalIrqEnable |=> !irqRequest;
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq without global enable");
   property p_write_load;
      @(posedge clk) disable iff (!rst_b) downWrite |=> downCount == $past(writeData) && downReload == downCount;
   endproperty
   a_write_load: assert property (p_write_load) else $error("down write not loaded");
   property p_under_flag;
      @(posedge clk) disable iff (!rst_b) underflow |=> downUnderflowFlag;
   endproperty
   a_under_flag: assert property (p_under_flag) else $error("underflow flag missing");
   property p_ir_oe;
      @(posedge clk) disable iff (!rst_b) waveCtrl.irEnable |=> irOe;
   endproperty
   a_ir_oe: assert property (p_ir_oe) else $error("IR pin not output");
   property p_up_write;
      @(posedge clk) disable iff (!rst_b) upWrite |=> upCount == $past(writeData);
   endproperty
   a_up_write: assert property (p_up_write) else $error("up write not loaded");
   property p_pres_clear;
      @(posedge clk) disable iff (!rst_b) prescalerAssignWrite |=> prescalerA == 8'h00;
   endproperty
   a_pres_clear: assert property (p_pres_clear) else $error("prescaler not cleared");
   property p_reload_ff;
      @(posedge clk) disable iff (!rst_b)
         underflow && !downWrite && !downCtrl.oneShot && !downCtrl.reloadSelect |=> downCount == 8'hff;
   endproperty
   a_reload_ff: assert property (p_reload_ff) else $error("restart not from 0xFF");
   property p_duty_zero;
      @(posedge clk) disable iff (!rst_b) cfgPinIsPwm && waveCtrl.pwmDuty == 8'h00
         && !waveCtrl.pwmActiveLow |=> !sharedWaveOut;
   endproperty
   a_duty_zero: assert property (p_duty_zero) else $error("PWM active at duty 0");
   c_overflow: cover property (@(posedge clk) $rose(upOverflowFlag));
   c_underflow: cover property (@(posedge clk) underflow);
   c_ir: cover property (@(posedge clk) $rose(irCarrier));
endmodule : timers_pwm_buzzer_ir
`default_nettype wire

/* ext_source.sv */
/*
 Partner model for the timer unit's far side: external count pin and low-speed oscillator.
 Assumes the bench's core clock; both sources stand low while run is low.
*/
`timescale 1ns/1ps
`default_nettype none
module ext_source
(
   // Clock
   input  wire logic       clk,
   // Control
   input  wire logic       run,
   input  wire logic [7:0] halfCycles,
   // Sources
   output logic            extPin,
   output logic            lowOsc
);
   logic [8:0] cnt;
   // Both sources are much slower than the core clock, so synchronised counting loses no edge
   always_ff @(posedge clk)
   begin
      if (!run)
      begin
         cnt    <= '0;
         extPin <= 1'b0;
         lowOsc <= 1'b0;
      end
      else if (cnt == {halfCycles, 1'b0} - 9'h1)
      begin
         cnt    <= '0;
         extPin <= ~extPin;
         lowOsc <= ~lowOsc;
      end
      else
      begin
         cnt <= cnt + 9'h1;
         if (cnt == {1'b0, halfCycles} - 9'h1)
            extPin <= ~extPin;
      end
   end
endmodule : ext_source
`default_nettype wire

/* tb_top.sv */
/*
 Self-checking bench for the timer, PWM, buzzer and IR carrier unit.
 Assumes the partner model ext_source; inputs change on the falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import tmr_pkg::*;
   logic clk, rst_b, global_irq_enable, upIe, downIe, cfgPwm, upW, downW, psW, upClr, downClr, irData, run, asyncCk;
   logic [7:0] wd, half, upCnt, dnCnt, dnRel, psCnt;
   logic upF, dnF, irq, wOut, wOe, irOut, irOe, extPin, lowOsc;
   up_ctrl_t   uc;
   down_ctrl_t dc;
   wave_ctrl_t wc;
   int fail_count, tests_run, cycles, n, acc;
   logic [7:0] snap;

   ext_source ext (.clk(clk), .run(run), .halfCycles(half), .extPin(extPin), .lowOsc(lowOsc));
   timers_pwm_buzzer_ir dut (.clk(clk), .rst_b(rst_b), .upCtrl(uc), .downCtrl(dc), .waveCtrl(wc),
      .globalIrqEnable(global_irq_enable), .upIrqEnable(upIe), .downIrqEnable(downIe), .cfgAsyncClock(asyncCk),
      .cfgPinIsPwm(cfgPwm), .upWrite(upW), .downWrite(downW), .writeData(wd),
      .prescalerAssignWrite(psW), .upFlagClear(upClr), .downFlagClear(downClr),
      .extCountClockPin(extPin), .lowSpeedOsc(lowOsc), .irPortData(irData), .upCount(upCnt),
      .downCount(dnCnt), .downReload(dnRel), .prescalerBCount(psCnt), .upOverflowFlag(upF),
      .downUnderflowFlag(dnF), .irqRequest(irq), .sharedWaveOut(wOut), .sharedWaveOe(wOe),
      .irOut(irOut), .irOe(irOe));

   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Hang guard: the whole sequence needs well under this many cycles
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 80000)
      begin
         fail_count++;
         conclude();
      end
   end

   task automatic conclude();
      if (fail_count == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : conclude

   task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp)
      begin
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
         fail_count++;
      end
   endtask : check

   // Tolerance compare for counts that depend on synchroniser latency and phase
   task automatic near(input string name, input int exp, input int tol, input logic [15:0] got);
      tests_run++;
      if ($isunknown(got) || int'(got) < exp - tol || int'(got) > exp + tol)
      begin
         $display("[FAIL] %s expected %0d seen %0d", name, exp, got);
         fail_count++;
      end
   endtask : near

   task automatic reset(input logic pwmPin);
      rst_b  = 1'b0;
      cfgPwm = pwmPin;
      repeat (6) @(negedge clk);
      rst_b = 1'b1;
   endtask : reset

   task automatic pulse(input int which, input logic [7:0] v);
      @(negedge clk);
      wd = v;
      {upW, downW, psW, upClr, downClr} = 5'b10000 >> which;
      @(negedge clk);
      {upW, downW, psW, upClr, downClr} = 5'b0;
   endtask : pulse

   // Cycles between two changes of the chosen pin; limit if it never changes
   task automatic toggle(input logic ir, input int limit, output int k);
      logic last;
      k    = 0;
      last = ir ? irOut : wOut;
      while (k < limit && (ir ? irOut : wOut) === last)
      begin
         @(negedge clk);
         k++;
      end
      if (k < limit)
      begin
         k    = 0;
         last = ir ? irOut : wOut;
         while (k < limit && (ir ? irOut : wOut) === last)
         begin
            @(negedge clk);
            k++;
         end
      end
   endtask : toggle

   initial
   begin
      {global_irq_enable, upIe, downIe, upW, downW, psW, upClr, downClr, irData, run, asyncCk} = '0;
      {fail_count, tests_run, cycles} = '0;
      wd = '0;
      half = 8'h05;
      uc = '0;
      uc.prescalerAssign = 1'b1;
      dc = '0;
      dc.prescalerEnableN = 1'b1;
      wc = '0;
      reset(1'b1);
      @(negedge clk);
      check("resetCounts", 8'h00, upCnt | psCnt | (dnCnt ^ 8'hff) | (dnRel ^ 8'hff));
      check("resetBits", 8'h00, {4'h0, upF, dnF, wOe, irOe});
      // One-shot down count from 5 stops at zero and sets the flag
      dc.enable = 1'b1;
      dc.oneShot = 1'b1;
      downIe = 1'b1;
      pulse(1, 8'h05);
      check("reload", 8'h05, dnRel);
      check("freshCount", 8'h05, dnCnt);
      repeat (20) @(negedge clk);
      check("oneShotEnd", 8'h00, dnCnt);
      check("oneShotFlag", 8'h01, {7'h0, dnF});
      check("irqGated", 8'h00, {7'h0, irq});
      global_irq_enable = 1'b1;
      repeat (3) @(negedge clk);
      check("irqOpen", 8'h01, {7'h0, irq});
      pulse(4, 8'h00);
      @(negedge clk);
      check("flagCleared", 8'h00, {6'h0, dnF, irq});
      // Continuous mode with reload never exceeds the reload value
      dc.oneShot = 1'b0;
      dc.reloadSelect = 1'b1;
      pulse(1, 8'h03);
      acc = 0;
      repeat (30)
      begin
         @(negedge clk);
         if (dnCnt > 8'h03)
            acc++;
      end
      check("reloadRange", 8'h00, 8'(acc));
      check("reloadFlag", 8'h01, {7'h0, dnF});
      dc.reloadSelect = 1'b0;
      n = 0;
      while (n < 12 && dnCnt !== 8'hff)
      begin
         @(negedge clk);
         n++;
      end
      check("restartFull", 8'hff, dnCnt);
      // Prescaler B at 1:2 halves the decrement rate
      dc.prescalerEnableN = 1'b0;
      pulse(1, 8'h80);
      repeat (40) @(negedge clk);
      near("downPrescaled", 8'h80 - 20, 2, {8'h0, dnCnt});
      // Prescaler count is readable and steps once per instruction clock
      snap = psCnt + 8'h01;
      @(negedge clk);
      check("presCount", snap, psCnt);
      // Up-counter overflow, refusal while disabled, and prescaler A ratios
      uc.enable = 1'b1;
      upIe = 1'b1;
      pulse(0, 8'hfd);
      repeat (8) @(negedge clk);
      check("upOverflow", 8'h01, {7'h0, upF});
      uc.enable = 1'b0;
      @(negedge clk);
      snap = upCnt;
      repeat (10) @(negedge clk);
      check("upHeld", snap, upCnt);
      uc.enable = 1'b1;
      uc.prescalerAssign = 1'b0;
      pulse(2, 8'h00);
      for (int r = 0; r < 3; r += 2)
      begin
         uc.ratio = 3'(r);
         pulse(0, 8'h00);
         repeat (64) @(negedge clk);
         near("upRatio", 64 >> (r + 1), 2, {8'h0, upCnt});
      end
      // External pin then low oscillator, both edge choices
      uc.prescalerAssign = 1'b1;
      uc.sourceSelect = 1'b1;
      run = 1'b1;
      for (int s = 0; s < 4; s++)
      begin
         {uc.lowClockSelect, uc.edgeSelect} = 2'(s);
         pulse(0, 8'h00);
         repeat (200) @(negedge clk);
         near("upExternal", s < 2 ? 20 : 10, 2, {8'h0, upCnt});
      end
      // Down timer from the external pin on falling edges, prescaler bypassed
      dc.prescalerEnableN = 1'b1;
      dc.sourceSelect = 1'b1;
      dc.edgeSelect = 1'b1;
      pulse(1, 8'h80);
      repeat (200) @(negedge clk);
      near("downExternal", 8'h80 - 20, 2, {8'h0, dnCnt});
      dc.sourceSelect = 1'b0;
      // Same low-oscillator count on the async path, one stage earlier; option changes only across reset
      asyncCk = 1'b1;
      reset(1'b1);
      pulse(0, 8'h00);
      repeat (200) @(negedge clk);
      near("upAsync", 10, 2, {8'h0, upCnt});
      asyncCk = 1'b0;
      // PWM: duty 0 never active in either polarity, duty 8 of a 17-tick frame
      reset(1'b1);
      dc.prescalerEnableN = 1'b1;
      dc.reloadSelect = 1'b1;
      wc.pwmOutputEnable = 1'b1;
      pulse(1, 8'h10);
      for (int p = 0; p < 3; p++)
      begin
         wc.pwmActiveLow = (p == 1);
         wc.pwmDuty = (p == 2) ? 8'h08 : 8'h00;
         acc = 0;
         repeat (170)
         begin
            @(negedge clk);
            acc += (wOut === 1'b1);
         end
         near("pwmHigh", p == 0 ? 0 : (p == 1 ? 170 : 80), p == 2 ? 6 : 0, 16'(acc));
      end
      check("pwmOe", 8'h01, {7'h0, wOe});
      // Buzzer on the shared pin from prescaler then from the timer
      reset(1'b0);
      dc.prescalerEnableN = 1'b0;
      wc.buzzerEnable = 1'b1;
      pulse(1, 8'h03);
      toggle(1'b0, 100, n);
      near("buzzPrescaler", 4, 1, 16'(n));
      check("buzzOe", 8'h01, {7'h0, wOe});
      wc.buzzerFreqSelect = 4'h8;
      toggle(1'b0, 100, n);
      near("buzzTimer", 16, 2, 16'(n));
      // IR carrier: both frequencies, data gating, polarity, release
      wc.irEnable = 1'b1;
      irData = 1'b1;
      for (int f = 0; f < 2; f++)
      begin
         wc.irFreqSelect = f[0];
         toggle(1'b1, 8000, n);
         near("irHalf", 250000000 / (f ? 57000 : 38000) / 2, 2, 16'(n));
      end
      check("irOe", 8'h01, {7'h0, irOe});
      irData = 1'b0;
      toggle(1'b1, 5000, n);
      near("irSilent", 5000, 0, 16'(n));
      wc.irPolaritySelect = 1'b1;
      toggle(1'b1, 8000, n);
      near("irInverted", 2192, 2, 16'(n));
      wc.irEnable = 1'b0;
      repeat (3) @(negedge clk);
      check("irReleased", 8'h00, {7'h0, irOe});
      conclude();
   end
endmodule : tb_top
`default_nettype wire
